// ==== src/tgc_timer_ctrl.sv ====
// Timer control/status registers, count source, filters and flags
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Clock gate bit 6 low: timer writes ignored, timer reads give zero.
// - Run bit counts; clearing it stops counting and resets PWM pin A level.
// - Capture B comes from filtered pin B, or event link input when set.
// - Filter clock: 00 div32, 01 div8, 10 system clock, 11 count source.
// - Enabled pin filters detect edges within five sample clocks.
// - Phase select off counts count source; on counts up/down from phases.
// - PWM select chooses timer mode or PWM mode.
// - Enables 7, 6, 5, 4 permit increments on their phase conditions.
// - Enables 3, 2, 1, 0 permit decrements on their phase conditions.
// - Clear source: none, match/capture A, or match/capture B.
// - External edge field: rising, falling or both edges.
// - Edge field applies only to external count sources.
// - Count source: fclk, /2, /4, /8, /32, pin A, pin B.
// - Phase counting mode overrides count source and edge fields for counting; filter clock 11 still uses them.
// - Interrupt enables gate overflow, underflow, match B, match A.
// - Direction flag reads 0 while decrementing.
// - Direction flag reads 1 while incrementing.
// - Overflow on FFFF to 0000, underflow on 0000 to FFFF.
// - Flag clears only by writing 0 after reading it as 1.
// - Match flags set on compare equality or on capture.
module tgc_timer_ctrl
  import tgc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clock,                   // System clock
  input  wire logic             rst_n,                   // Sync reset, low
  input  wire logic [ADDR_W-1:0] sfr_addr,               // Register address
  input  wire logic             sfr_wr,                  // Write strobe
  input  wire logic             sfr_rd,                  // Read strobe
  input  wire logic [7:0]       sfr_wdata,               // Write data
  output logic      [7:0]       sfr_rdata_r,             // Read data
  input  wire logic             ext_clock_phase_a,       // Clock / phase A
  input  wire logic             ext_clock_phase_b,       // Clock / phase B
  input  wire logic             capture_compare_pin_a_i, // Pin A level
  input  wire logic             capture_compare_pin_b_i, // Pin B level
  output logic                  capture_compare_pin_a_o_r,    // Pin A drive
  output logic                  capture_compare_pin_a_oe_n_r, // Pin A enable
  input  wire logic             event_link_unit_capture, // Event pulse
  input  wire logic             cap_use_a,               // A in capture use
  input  wire logic             cap_use_b,               // B in capture use
  input  wire logic [1:0]       cap_edge_a,              // A capture edge
  input  wire logic [1:0]       cap_edge_b,              // B capture edge
  input  wire logic [CNT_W-1:0] general_reg_a,           // Compare value A
  input  wire logic [CNT_W-1:0] general_reg_b,           // Compare value B
  output logic      [CNT_W-1:0] main_counter_r,          // Counter value
  output logic                  capture_a_strobe_r,      // Load GR A
  output logic                  capture_b_strobe_r,      // Load GR B
  output logic                  irq_r                    // Interrupt
);

  // ************************************************************
  // Declarations
  // ************************************************************
  tgc_byte_t          peripheral_clock_enable_1_r, mode_r, phase_r, src_r;
  logic [3:0]         ien_r, flags_r, flags_nxt, seen_r;
  logic [PRESC_W-1:0] presc_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [2:0]         src_sel;
  logic [1:0]         lvl, lvl_q, raw, den;
  logic [1:0]         dfck, clr_sel, edge_sel;
  logic               dir_r, pa_q, pb_q, en, run, phase_m, wr_stat;
  logic               src_tick, filt_tick, up_p, dn_p, inc, dec, clr, cnt_ev;
  logic               mat_a, mat_b, cap_a_ev, cap_b_ev, ovf_ev, udf_ev;

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                    input logic prv);
    case (sel)
      EDGE_RISE: edge_hit = cur & ~prv;
      EDGE_FALL: edge_hit = ~cur & prv;
      EDGE_BOTH: edge_hit = cur ^ prv;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  assign en       = peripheral_clock_enable_1_r[CLK_GATE_BIT];
  assign run      = mode_r[MODE_RUN];
  assign phase_m  = mode_r[MODE_PHASE];
  assign dfck     = mode_r[MODE_DFCK_LO +: 2];
  assign clr_sel  = src_r[SRC_CLR_LO +: 2];
  assign edge_sel = src_r[SRC_EDGE_LO +: 2];
  assign src_sel  = src_r[SRC_SEL_LO +: 3];
  assign wr_stat  = sfr_wr && en && (sfr_addr == ADDR_STAT);

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      peripheral_clock_enable_1_r <= RST_REG;
    end else if (sfr_wr && sfr_addr == ADDR_CLK_EN) begin
      peripheral_clock_enable_1_r <= sfr_wdata;
    end
  end

  // Gate low holds the timer in reset, so writes are lost
  always_ff @(posedge clock) begin
    if (!rst_n || !en) begin
      mode_r  <= RST_REG;
      phase_r <= RST_REG;
      src_r   <= RST_REG;
      ien_r   <= RST_REG[3:0];
    end else if (sfr_wr) begin
      case (sfr_addr)
        ADDR_MODE:  mode_r  <= sfr_wdata;
        ADDR_PHASE: phase_r <= sfr_wdata;
        ADDR_SRC:   src_r   <= {1'b0, sfr_wdata[6:0]};
        ADDR_IEN:   ien_r   <= sfr_wdata[3:0];
        default:    ;
      endcase
    end
  end

  // ************************************************************
  // Prescaler and count source
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n || !en) begin
      presc_r <= '0;
      pa_q    <= 1'b0;
      pb_q    <= 1'b0;
      lvl_q   <= 2'b00;
    end else begin
      presc_r <= presc_r + 1'b1;
      pa_q    <= ext_clock_phase_a;
      pb_q    <= ext_clock_phase_b;
      lvl_q   <= lvl;
    end
  end

  always_comb begin
    case (src_sel)
      SRC_DIV1:  src_tick = 1'b1;
      SRC_DIV2:  src_tick = presc_r[0];
      SRC_DIV4:  src_tick = &presc_r[1:0];
      SRC_DIV8:  src_tick = &presc_r[2:0];
      SRC_DIV32: src_tick = &presc_r;
      // Edge field matters only for the pin sources
      SRC_EXTA:  src_tick = edge_hit(edge_sel, ext_clock_phase_a, pa_q);
      SRC_EXTB:  src_tick = edge_hit(edge_sel, ext_clock_phase_b, pb_q);
      default:   src_tick = 1'b0;
    endcase
  end

  always_comb begin
    case (dfck)
      2'h0:    filt_tick = &presc_r;
      2'h1:    filt_tick = &presc_r[2:0];
      2'h2:    filt_tick = 1'b1;
      default: filt_tick = src_tick;
    endcase
  end

  // ************************************************************
  // Pin filters
  // ************************************************************
  assign raw = {capture_compare_pin_b_i, capture_compare_pin_a_i};
  assign den = {mode_r[MODE_DFB], mode_r[MODE_DFA]};

  // Three equal samples pass; worst case edge delay stays within five
  generate
    for (genvar i = 0; i < 2; i++) begin : g_filt
      logic [FILT_N-1:0] samp_r;
      logic              filt_r;
      always_ff @(posedge clock) begin
        if (!rst_n || !en) begin
          samp_r <= '0;
          filt_r <= 1'b0;
        end else begin
          if (filt_tick) begin
            samp_r <= {samp_r[FILT_N-2:0], raw[i]};
          end
          if (&samp_r || ~|samp_r) begin
            filt_r <= samp_r[0];
          end
        end
      end
      assign lvl[i] = den[i] ? filt_r : raw[i];
    end
  endgenerate

  // ************************************************************
  // Count events
  // ************************************************************
  always_comb begin
    up_p = (phase_r[7] & ~ext_clock_phase_a & ext_clock_phase_b & ~pb_q)
         | (phase_r[6] & ext_clock_phase_b & ext_clock_phase_a & ~pa_q)
         | (phase_r[5] & ext_clock_phase_a & ~ext_clock_phase_b & pb_q)
         | (phase_r[4] & ~ext_clock_phase_b & ~ext_clock_phase_a & pa_q);
    dn_p = (phase_r[3] & ext_clock_phase_b & ~ext_clock_phase_a & pa_q)
         | (phase_r[2] & ~ext_clock_phase_a & ~ext_clock_phase_b & pb_q)
         | (phase_r[1] & ~ext_clock_phase_b & ext_clock_phase_a & ~pa_q)
         | (phase_r[0] & ext_clock_phase_a & ext_clock_phase_b & ~pb_q);
  end

  // Phase mode overrides the source select for counting; filter clock 11 still uses it
  assign inc    = run && (phase_m ? up_p : src_tick);
  assign dec    = run && phase_m && dn_p && !up_p;
  assign cnt_ev = inc || dec;
  assign mat_a  = cnt_ev && !cap_use_a && main_counter_r == general_reg_a;
  assign mat_b  = cnt_ev && !cap_use_b && main_counter_r == general_reg_b;
  assign cap_a_ev = run && cap_use_a && edge_hit(cap_edge_a, lvl[0], lvl_q[0]);
  assign cap_b_ev = run && cap_use_b && (mode_r[MODE_CAPB] ? event_link_unit_capture
                  : edge_hit(cap_edge_b, lvl[1], lvl_q[1]));
  assign clr    = (clr_sel == CLR_A && (mat_a || cap_a_ev))
               || (clr_sel == CLR_B && (mat_b || cap_b_ev));
  assign ovf_ev = (inc || clr) && (&main_counter_r);
  assign udf_ev = dec && !clr && main_counter_r == '0;

  always_comb begin
    if (clr) begin
      cnt_nxt = '0;
    end else if (inc) begin
      cnt_nxt = main_counter_r + 1'b1;
    end else if (dec) begin
      cnt_nxt = main_counter_r - 1'b1;
    end else begin
      cnt_nxt = main_counter_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !en) begin
      main_counter_r <= '0;
      dir_r          <= 1'b0;
    end else begin
      main_counter_r <= cnt_nxt;
      if (inc) begin
        dir_r <= 1'b1;
      end else if (dec) begin
        dir_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Flags, interrupt, capture strobes, PWM pin
  // ************************************************************
  // Set beats a same-cycle clear so no event is lost
  always_comb begin
    flags_nxt = flags_r & ~(wr_stat ? (seen_r & ~sfr_wdata[3:0]) : 4'h0);
    flags_nxt = flags_nxt | {ovf_ev, udf_ev, mat_b || cap_b_ev, mat_a || cap_a_ev};
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !en) begin
      flags_r <= 4'h0;
      seen_r  <= 4'h0;
      irq_r   <= 1'b0;
      capture_a_strobe_r <= 1'b0;
      capture_b_strobe_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      if (wr_stat) begin
        seen_r <= 4'h0;
      end else if (sfr_rd && sfr_addr == ADDR_STAT) begin
        seen_r <= flags_r;
      end
      irq_r <= |(flags_r & ien_r);
      capture_a_strobe_r <= cap_a_ev;
      capture_b_strobe_r <= cap_b_ev;
    end
  end

  // PWM: high from match B, low from match A
  always_ff @(posedge clock) begin
    if (!rst_n || !en) begin
      capture_compare_pin_a_o_r    <= PWM_INIT;
      capture_compare_pin_a_oe_n_r <= 1'b1;
    end else begin
      capture_compare_pin_a_oe_n_r <= !mode_r[MODE_PWM];
      if (!run || !mode_r[MODE_PWM]) begin
        capture_compare_pin_a_o_r <= PWM_INIT;
      end else if (mat_a) begin
        capture_compare_pin_a_o_r <= 1'b0;
      end else if (mat_b) begin
        capture_compare_pin_a_o_r <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sfr_rdata_r <= RST_REG;
    end else if (sfr_rd) begin
      case (sfr_addr)
        ADDR_CLK_EN: sfr_rdata_r <= peripheral_clock_enable_1_r;
        ADDR_MODE:   sfr_rdata_r <= mode_r;
        ADDR_PHASE:  sfr_rdata_r <= phase_r;
        ADDR_SRC:    sfr_rdata_r <= src_r;
        ADDR_IEN:    sfr_rdata_r <= {4'h0, ien_r};
        ADDR_STAT:   sfr_rdata_r <= {3'h0, dir_r, flags_r};
        default:     sfr_rdata_r <= RST_REG;
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_gate_off_read;
    !en && sfr_rd && sfr_addr != ADDR_CLK_EN;
  endsequence
  sequence s_unseen_zero_write;
    wr_stat && !seen_r[STAT_MA] && !sfr_wdata[STAT_MA] && flags_r[STAT_MA];
  endsequence

  a_gate_read_zero: assert property (s_gate_off_read |=> sfr_rdata_r == 8'h00)
    else $error("timer read with gate off not zero");
  a_gate_write_lost: assert property (!en && sfr_wr && sfr_addr == ADDR_MODE
    |=> mode_r == 8'h00)
    else $error("timer write with gate off took effect");
  a_stop_holds_count: assert property (en && !run && !sfr_wr
    |=> main_counter_r == $past(main_counter_r))
    else $error("counter moved while stopped");
  a_pwm_stop_level: assert property (en && !run && !sfr_wr
    |=> capture_compare_pin_a_o_r == PWM_INIT)
    else $error("pin A not at initial level when stopped");
  a_fclk_counts_up: assert property (run && !phase_m && src_sel == SRC_DIV1
    && clr_sel == CLR_NONE && !sfr_wr |=> main_counter_r == CNT_W'($past(main_counter_r) + 1'b1)
    && dir_r)
    else $error("system clock source did not increment");
  a_dir_down: assert property (dec && !sfr_wr |=> !dir_r)
    else $error("direction not 0 after decrement");
  a_ovf_flag_set: assert property (ovf_ev && !sfr_wr ##1 1 |-> flags_r[STAT_OVF])
    else $error("overflow flag not set");
  a_udf_wraps: assert property (udf_ev && !sfr_wr
    |=> flags_r[STAT_UDF] && &main_counter_r)
    else $error("underflow wrap not flagged");
  a_clear_needs_read: assert property (s_unseen_zero_write |=> flags_r[STAT_MA])
    else $error("flag cleared without prior read");
  a_clear_src_a: assert property (clr_sel == CLR_A && mat_a && !sfr_wr
    |=> main_counter_r == '0 ##1 flags_r[STAT_MA] || !en)
    else $error("match A did not clear counter");
  a_irq_gating: assert property (en && !sfr_wr ##1 en
    |-> irq_r == |($past(flags_r & ien_r)))
    else $error("interrupt does not follow enabled flags");

endmodule : tgc_timer_ctrl
`default_nettype wire

// ==== src/tgc_pkg.sv ====
// Constants shared by the timer control register block
package tgc_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          ADDR_W      = 20;
  localparam logic [19:0] ADDR_CLK_EN = 20'hF007A;
  localparam logic [19:0] ADDR_MODE   = 20'hF0250;
  localparam logic [19:0] ADDR_PHASE  = 20'hF0251;
  localparam logic [19:0] ADDR_SRC    = 20'hF0252;
  localparam logic [19:0] ADDR_IEN    = 20'hF0253;
  localparam logic [19:0] ADDR_STAT   = 20'hF0254;
  localparam logic [7:0]  RST_REG     = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CLK_GATE_BIT = 6;
  localparam int MODE_RUN     = 7;
  localparam int MODE_CAPB    = 6;
  localparam int MODE_DFCK_LO = 4;
  localparam int MODE_DFB     = 3;
  localparam int MODE_PWM     = 2;
  localparam int MODE_DFA     = 1;
  localparam int MODE_PHASE   = 0;
  localparam int SRC_CLR_LO   = 5;
  localparam int SRC_EDGE_LO  = 3;
  localparam int SRC_SEL_LO   = 0;
  localparam int STAT_DIR     = 4;
  localparam int STAT_OVF     = 3;
  localparam int STAT_UDF     = 2;
  localparam int STAT_MB      = 1;
  localparam int STAT_MA      = 0;

  // ************************************************************
  // Encodings and counts
  // ************************************************************
  localparam logic [2:0] SRC_DIV1  = 3'h0;
  localparam logic [2:0] SRC_DIV2  = 3'h1;
  localparam logic [2:0] SRC_DIV4  = 3'h2;
  localparam logic [2:0] SRC_DIV8  = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXTA  = 3'h5;
  localparam logic [2:0] SRC_EXTB  = 3'h7;
  localparam logic [1:0] CLR_NONE  = 2'h0;
  localparam logic [1:0] CLR_A     = 2'h1;
  localparam logic [1:0] CLR_B     = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam int         PRESC_W   = 5;
  localparam int         FILT_N    = 3;
  localparam logic       PWM_INIT  = 1'b0;

  typedef logic [7:0] tgc_byte_t;
endpackage : tgc_pkg

// ==== tb/tgc_pins_model.sv ====
// Pin-side model: external clock, two-phase encoder and capture pin B
`timescale 1ns/1ps
`default_nettype none
module tgc_pins_model (
  input  wire logic clock,   // System clock
  output logic      phase_a, // Clock / phase A
  output logic      phase_b, // Clock / phase B
  output logic      pin_b    // Capture pin B
);
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    pin_b   = 1'b0;
  end
  // ********************
  // Pin stimulus
  // ********************
  // Levels change just after an edge, then rest two cycles
  task automatic put(input logic [2:0] v);
    @(posedge clock);
    {phase_a, phase_b, pin_b} <= v;
    repeat (2) @(posedge clock);
  endtask : put
  task automatic pinb(input logic v);
    put({phase_a, phase_b, v});
  endtask : pinb
  task automatic pulse(input logic on_b, input int n);
    repeat (n) begin
      put({~on_b, on_b, pin_b});
      put({2'b00, pin_b});
    end
  endtask : pulse
  // One full Gray cycle of four edges, ending at 00
  task automatic quad(input logic up);
    logic [7:0] s;
    s = up ? 8'b01_11_10_00 : 8'b10_11_01_00;
    for (int i = 3; i >= 0; i--) begin
      put({s[2*i+:2], pin_b});
    end
  endtask : quad
endmodule : tgc_pins_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the timer control register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tgc_pkg::*;
  logic              clock, rst_n, sfr_wr, sfr_rd, ev_cap, cap_use_b, cap_use_a, pin_a;
  logic [ADDR_W-1:0] sfr_addr;
  logic [7:0]        sfr_wdata, sfr_rdata_r;
  logic              phase_a, phase_b, pin_b, pin_a_o, pin_a_oe_n, strobe_b, strobe_a, irq;
  logic [15:0]       gr_a, gr_b, cnt;
  int                n_mismatch, checked, n_strobe, n_strobe_a;

  tgc_timer_ctrl tgc_timer_ctrl_i (
    .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .ext_clock_phase_a(phase_a), .ext_clock_phase_b(phase_b),
    .capture_compare_pin_a_i(pin_a), .capture_compare_pin_b_i(pin_b),
    .capture_compare_pin_a_o_r(pin_a_o), .capture_compare_pin_a_oe_n_r(pin_a_oe_n),
    .event_link_unit_capture(ev_cap), .cap_use_a(cap_use_a), .cap_use_b(cap_use_b),
    .cap_edge_a(2'h0), .cap_edge_b(EDGE_RISE),
    .general_reg_a(gr_a), .general_reg_b(gr_b), .main_counter_r(cnt),
    .capture_a_strobe_r(strobe_a), .capture_b_strobe_r(strobe_b), .irq_r(irq)
  );
  tgc_pins_model tgc_pins_model_i (
    .clock(clock), .phase_a(phase_a), .phase_b(phase_b), .pin_b(pin_b)
  );

  // ********************
  // Bus and check helpers
  // ********************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    cyc(1);
    d = sfr_rdata_r;
  endtask : rd
  task automatic ev_pulse();
    @(posedge clock);
    ev_cap <= 1'b1;
    @(posedge clock);
    ev_cap <= 1'b0;
  endtask : ev_pulse
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ********************
  // Scenarios
  // ********************
  task automatic t_regs();
    logic [7:0] d;
    wr(ADDR_MODE, 8'h81);
    rd(ADDR_MODE, d);
    chk(d, 16'h0000, "gated write");
    wr(ADDR_CLK_EN, 8'h40);
    rd(ADDR_CLK_EN, d);
    chk(d, 16'h0040, "gate reg");
    rd(ADDR_MODE, d);
    chk(d, 16'h0000, "mode after gate");
    rd(20'hF0260, d);
    chk(d, 16'h0000, "unmapped");
    $display("regs done");
  endtask : t_regs
  task automatic t_div();
    logic [2:0]  sv [5] = '{SRC_DIV1, SRC_DIV2, SRC_DIV4, SRC_DIV8, SRC_DIV32};
    int          dv [5] = '{1, 2, 4, 8, 32};
    logic [15:0] c0;
    foreach (sv[i]) begin
      wr(ADDR_SRC, {3'h0, EDGE_FALL, sv[i]});
      wr(ADDR_MODE, 8'h80);
      cyc(2);
      c0 = cnt;
      cyc(8 * dv[i]);
      chk(cnt - c0, 16'h0008, "prescale");
      wr(ADDR_MODE, 8'h00);
    end
    cyc(1);
    c0 = cnt;
    cyc(6);
    chk(cnt, c0, "stopped");
    $display("div done");
  endtask : t_div
  task automatic t_ext();
    logic [15:0] c0;
    for (int s = 0; s < 2; s++) begin
      for (int e = 0; e < 3; e++) begin
        wr(ADDR_SRC, {3'h0, e[1:0], s ? SRC_EXTB : SRC_EXTA});
        wr(ADDR_MODE, 8'h80);
        cyc(1);
        c0 = cnt;
        tgc_pins_model_i.pulse(s[0], 3);
        cyc(1);
        chk(cnt - c0, e == 2 ? 16'h0006 : 16'h0003, "ext edge");
        wr(ADDR_MODE, 8'h00);
      end
    end
    $display("ext done");
  endtask : t_ext
  task automatic t_phase();
    logic [7:0]  d;
    logic [15:0] c0;
    wr(ADDR_CLK_EN, 8'h00);
    wr(ADDR_CLK_EN, 8'h40);
    wr(ADDR_MODE, 8'h81);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_PHASE, 8'h01 << i);
      cyc(1);
      c0 = cnt;
      tgc_pins_model_i.quad(i > 3);
      cyc(1);
      chk(cnt - c0, i > 3 ? 16'h0001 : 16'hFFFF, "phase bit");
      if (i == 3) begin
        rd(ADDR_STAT, d);
        chk(d, 16'h0004, "down status");
      end
    end
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_STAT, d);
    chk(d, 16'h001C, "up status");
    wr(ADDR_STAT, 8'h1F);
    wr(ADDR_STAT, 8'h00);
    rd(ADDR_STAT, d);
    chk(d, 16'h001C, "no clear");
    wr(ADDR_STAT, 8'h00);
    rd(ADDR_STAT, d);
    chk(d, 16'h0010, "cleared");
    $display("phase done");
  endtask : t_phase
  task automatic t_clear();
    logic [7:0]  d;
    logic [15:0] mx;
    logic        hi, lo;
    @(posedge clock);
    gr_a <= 16'h0005;
    gr_b <= 16'h0003;
    wr(ADDR_IEN, 8'h01);
    for (int k = 2; k > 0; k--) begin
      wr(ADDR_SRC, {1'b0, k[1:0], 5'h00});
      wr(ADDR_MODE, 8'h80);
      mx = 16'h0000;
      repeat (30) begin
        cyc(1);
        mx = (cnt > mx) ? cnt : mx;
      end
      chk(mx, k == 2 ? 16'h0003 : 16'h0005, "clear top");
      wr(ADDR_MODE, 8'h00);
    end
    cyc(1);
    chk(irq, 16'h0001, "irq on");
    wr(ADDR_STAT, 8'h00);
    rd(ADDR_STAT, d);
    chk(d, 16'h0013, "match flags");
    wr(ADDR_IEN, 8'h0C);
    cyc(3);
    chk(irq, 16'h0000, "irq masked");
    wr(ADDR_MODE, 8'h84);
    hi = 1'b0;
    lo = 1'b0;
    repeat (30) begin
      cyc(1);
      hi = hi | pin_a_o;
      lo = lo | ~pin_a_o;
    end
    chk({hi, lo, pin_a_oe_n}, 16'h0006, "pwm drive");
    wr(ADDR_MODE, 8'h04);
    cyc(2);
    chk(pin_a_o, PWM_INIT, "pwm stop");
    wr(ADDR_MODE, 8'h00);
    cyc(2);
    chk(pin_a_oe_n, 16'h0001, "timer mode");
    $display("clear done");
  endtask : t_clear
  task automatic t_cap();
    int k0;
    @(posedge clock);
    cap_use_b <= 1'b1;
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_MODE, 8'hC0);
    k0 = n_strobe;
    ev_pulse();
    cyc(4);
    chk(n_strobe - k0, 16'h0001, "event cap");
    k0 = n_strobe;
    tgc_pins_model_i.pinb(1'b1);
    tgc_pins_model_i.pinb(1'b0);
    cyc(8);
    chk(n_strobe - k0, 16'h0000, "pin ignored");
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_MODE, 8'h28);
    wr(ADDR_MODE, 8'hA8);
    k0 = n_strobe;
    ev_pulse();
    cyc(4);
    chk(n_strobe - k0, 16'h0000, "event ignored");
    tgc_pins_model_i.pinb(1'b1);
    cyc(6);
    chk(n_strobe - k0, 16'h0001, "filtered pin");
    $display("cap done");
  endtask : t_cap
  task automatic t_capa();
    logic [7:0] d;
    int         k0;
    wr(ADDR_MODE, 8'h00);
    @(posedge clock);
    cap_use_a <= 1'b1;
    wr(ADDR_SRC, 8'h00);
    wr(ADDR_MODE, 8'h22);
    rd(ADDR_STAT, d);
    wr(ADDR_STAT, 8'h00);
    wr(ADDR_MODE, 8'hA2);
    k0 = n_strobe_a;
    @(posedge clock);
    pin_a <= 1'b1;
    cyc(8);
    chk(n_strobe_a - k0, 16'h0001, "pin A capture");
    rd(ADDR_STAT, d);
    chk(d, 16'h0011, "capture A flag");
    wr(ADDR_MODE, 8'h00);
    $display("capa done");
  endtask : t_capa

  always @(posedge clock) begin
    if (strobe_b === 1'b1) begin
      n_strobe++;
    end
    if (strobe_a === 1'b1) begin
      n_strobe_a++;
    end
  end
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {rst_n, sfr_wr, sfr_rd, ev_cap, cap_use_b, cap_use_a, pin_a} = 7'h00;
    {n_mismatch, checked, n_strobe, n_strobe_a} = {32'd0, 32'd0, 32'd0, 32'd0};
    sfr_addr  = 20'h00000;
    sfr_wdata = 8'h00;
    gr_a      = 16'h1234;
    gr_b      = 16'h1234;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_div();
    t_ext();
    t_phase();
    t_clear();
    t_cap();
    t_capa();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
